// File: rtl/acs_pkg.sv
// calibration sequencer package: register map, field layout, mode codes
// assumes a single 200 MHz clock domain and an AXI4-Lite register bus
package acs_pkg;
   // register byte offsets
   localparam logic [7:0] ACS_MODE_ADDR = 8'h00;
   localparam logic [7:0] ACS_STATUS_ADDR = 8'h04;
   localparam logic [7:0] ACS_DATA_ADDR = 8'h08;
   localparam logic [7:0] ACS_OFFSET_ADDR = 8'h0c;
   localparam logic [7:0] ACS_FULLSCALE_ADDR = 8'h10;
   localparam logic [7:0] ACS_IRQ_STAT_ADDR = 8'h14;
   localparam logic [7:0] ACS_IRQ_MASK_ADDR = 8'h18;
   // mode register fields
   localparam int ACS_MODE_LSB = 0;
   localparam int ACS_RATE_LSB = 3;
   localparam int ACS_CHOP_BIT = 13;
   localparam int ACS_SINC3_BIT = 14;
   localparam int ACS_CLK_DIV_BIT = 15;
   localparam int ACS_GAIN_LSB = 16;
   localparam int ACS_MODE_W = 19;
   // status register fields
   localparam int ACS_STAT_RDY_N_BIT = 0;
   localparam int ACS_STAT_BUSY_BIT = 1;
   localparam int ACS_STAT_CAL_LSB = 2;
   // interrupt bits
   localparam int ACS_IRQ_CONV_BIT = 0;
   localparam int ACS_IRQ_CAL_BIT = 1;
   localparam int ACS_IRQ_W = 2;
   // reset values
   localparam logic [18:0] ACS_MODE_RESET = 19'h00312;
   localparam logic [23:0] ACS_OFFSET_RESET = 24'h800000;
   localparam logic [23:0] ACS_FULLSCALE_RESET = 24'h800000;
   // settling periods in output-data-rate periods
   localparam logic [4:0] ACS_SETTLE_SINC4 = 5'h04;
   localparam logic [4:0] ACS_SETTLE_SINC3 = 5'h03;
   localparam logic [4:0] ACS_SETTLE_CHOP = 5'h02;
   // coefficient fraction bits: full-scale 0x800000 is unity
   localparam int ACS_COEF_FRAC = 23;
   // analog input routing
   localparam logic [1:0] ACS_ROUTE_PINS = 2'h0;
   localparam logic [1:0] ACS_ROUTE_ZERO = 2'h1;
   localparam logic [1:0] ACS_ROUTE_FULL = 2'h2;
   // axi responses
   localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;
   // operating mode codes
   typedef enum logic [2:0] {
      ACS_OP_CONTINUOUS = 3'h0,
      ACS_OP_SINGLE = 3'h1,
      ACS_OP_IDLE = 3'h2,
      ACS_OP_POWER_DOWN = 3'h3,
      ACS_OP_INT_ZERO = 3'h4,
      ACS_OP_INT_FULL = 3'h5,
      ACS_OP_SYS_ZERO = 3'h6,
      ACS_OP_SYS_FULL = 3'h7
   } acs_op_type;
   typedef enum logic [0:0] {ACS_CAL_IDLE, ACS_CAL_RUN} acs_cal_state_type;
endpackage

// File: rtl/acs_corrector.sv
// offset subtraction and full-scale scaling of one raw conversion result
// assumes raw_valid is a one-cycle pulse; result appears one cycle later
module acs_corrector
   import acs_pkg::*;
#(
   parameter int DATA_W = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic raw_valid,
   input wire logic [DATA_W-1:0] raw_data,
   input wire logic [DATA_W-1:0] offset_coef,
   input wire logic [DATA_W-1:0] fullscale_coef,
   output logic out_valid,
   output logic [DATA_W-1:0] out_data
);
   logic signed [DATA_W:0] diff;
   logic signed [2*DATA_W+1:0] prod;
   logic signed [2*DATA_W+1:0] scaled;

   // subtract first, then multiply, then clamp to the code range
   always_comb begin
      diff = $signed({1'b0, raw_data}) - $signed({1'b0, offset_coef});
      prod = diff * $signed({1'b0, fullscale_coef});
      scaled = prod >>> ACS_COEF_FRAC;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (ce) begin
         out_valid <= raw_valid;
         if (raw_valid) begin
            if (scaled < 0)
               out_data <= '0;
            else if (scaled > $signed({{(DATA_W+2){1'b0}}, {DATA_W{1'b1}}}))
               out_data <= '1;
            else
               out_data <= scaled[DATA_W-1:0];
         end
      end
   end
endmodule // acs_corrector

// File: rtl/acs_sequencer.sv
// calibration sequencer for a sigma-delta converter, with AXI4-Lite registers
// assumes raw conversions arrive as one-cycle pulses synchronous to aclk
// Operation
// RULE1 - four calibration modes started by mode write
// RULE2 - subtract offset, then multiply by full-scale
// RULE3 - calibration start drives ready pin and bit high
// RULE4 - completion updates coefficient, clears ready, idles
// RULE5 - internal calibrations route zero or full source
// RULE6 - host runs zero-scale before full-scale
// RULE7 - chop off zero-scale takes one settling time
// RULE8 - chop on zero-scale takes two periods
// RULE9 - internal full-scale doubles above unity gain
// RULE10 - system full-scale takes one settling time
// RULE11 - internal full-scale needs rate word multiple of 16
// RULE12 - clock divide doubles internal full-scale time
// RULE13 - coefficients readable always, writable when idle
// RULE14 - coefficients are 24-bit and host writable
// RULE15 - host recalibrates after gain change
// RULE16 - no data register update during calibration
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int DATA_W = 24,
   parameter int PERIOD_UNIT = 1024
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cs_n,
   input wire logic raw_valid,
   input wire logic [DATA_W-1:0] raw_data,
   output logic [1:0] input_route,
   output logic dout_rdy,
   output logic irq
);
   logic [ACS_MODE_W-1:0] mode_reg;
   logic [DATA_W-1:0] data_reg;
   logic [DATA_W-1:0] offset_coef;
   logic [DATA_W-1:0] fullscale_coef;
   logic [ACS_IRQ_W-1:0] irq_stat;
   logic [ACS_IRQ_W-1:0] irq_mask;
   logic rdy_n;
   acs_cal_state_type cal_state;
   acs_op_type cal_op;
   logic [19:0] period_cnt;
   logic [4:0] periods_left;
   logic [DATA_W-1:0] cal_sample;
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic wr_fire;
   logic coef_writable;
   logic mode_wr;
   logic cal_start;
   logic cal_done;
   logic corr_valid;
   logic [DATA_W-1:0] corr_data;
   logic [4:0] next_periods;
   logic [19:0] period_len;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic wr_ok;
   logic [31:0] mode_merged;

   // merge byte lanes of a write into an old word
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      end
      return res;
   endfunction

   acs_corrector #(
      .DATA_W(DATA_W)
   ) u_corrector (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .raw_valid(raw_valid),
      .raw_data(raw_data),
      .offset_coef(offset_coef),
      .fullscale_coef(fullscale_coef),
      .out_valid(corr_valid),
      .out_data(corr_data)
   );

   // write decode and strobe merge
   always_comb begin
      wr_fire = aw_held && w_held && !s_axi_bvalid;
      coef_writable = (acs_op_type'(mode_reg[ACS_MODE_LSB +: 3]) == ACS_OP_IDLE) ||
                      (acs_op_type'(mode_reg[ACS_MODE_LSB +: 3]) == ACS_OP_POWER_DOWN);
      mode_merged = merge_strb({{(32-ACS_MODE_W){1'b0}}, mode_reg}, w_data, w_strb);
      mode_wr = wr_fire && (aw_addr == ACS_MODE_ADDR);
      cal_start = mode_wr && mode_merged[ACS_MODE_LSB + 2]; // RULE1
      case (aw_addr)
         ACS_MODE_ADDR, ACS_IRQ_STAT_ADDR, ACS_IRQ_MASK_ADDR: wr_ok = 1'b1;
         ACS_OFFSET_ADDR, ACS_FULLSCALE_ADDR: wr_ok = coef_writable; // RULE13
         default: wr_ok = 1'b0;
      endcase
   end

   // settling periods for the requested calibration
   always_comb begin
      if (mode_merged[ACS_CHOP_BIT])
         next_periods = ACS_SETTLE_CHOP; // RULE8
      else if (mode_merged[ACS_SINC3_BIT])
         next_periods = ACS_SETTLE_SINC3; // RULE7
      else
         next_periods = ACS_SETTLE_SINC4; // RULE7
      if (acs_op_type'(mode_merged[ACS_MODE_LSB +: 3]) == ACS_OP_INT_FULL) begin
         if (mode_merged[ACS_GAIN_LSB +: 3] != 3'h0)
            next_periods = next_periods << 1; // RULE9
         if (mode_merged[ACS_CLK_DIV_BIT])
            next_periods = next_periods << 1; // RULE12
      end
      // system calibrations use the plain settling count
      period_len = 20'(mode_reg[ACS_RATE_LSB +: 10]) * 20'(PERIOD_UNIT);
   end

   // write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b1;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'h0};
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   // write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_wready <= 1'b1;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ACS_RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read mux; coefficients readable in any mode
   always_comb begin
      rd_ok = 1'b1;
      rd_mux = '0;
      case ({s_axi_araddr[7:2], 2'h0})
         ACS_MODE_ADDR: rd_mux = {{(32-ACS_MODE_W){1'b0}}, mode_reg};
         ACS_STATUS_ADDR: begin
            rd_mux[ACS_STAT_RDY_N_BIT] = rdy_n;
            rd_mux[ACS_STAT_BUSY_BIT] = (cal_state == ACS_CAL_RUN);
            rd_mux[ACS_STAT_CAL_LSB +: 3] = cal_op;
         end
         ACS_DATA_ADDR: rd_mux = {{(32-DATA_W){1'b0}}, data_reg};
         ACS_OFFSET_ADDR: rd_mux = {{(32-DATA_W){1'b0}}, offset_coef}; // RULE13
         ACS_FULLSCALE_ADDR: rd_mux = {{(32-DATA_W){1'b0}}, fullscale_coef}; // RULE13
         ACS_IRQ_STAT_ADDR: rd_mux = {{(32-ACS_IRQ_W){1'b0}}, irq_stat};
         ACS_IRQ_MASK_ADDR: rd_mux = {{(32-ACS_IRQ_W){1'b0}}, irq_mask};
         default: rd_ok = 1'b0;
      endcase
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= ACS_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // mode register; a finished calibration falls back to idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= ACS_MODE_RESET;
      end else if (ce) begin
         if (mode_wr)
            mode_reg <= mode_merged[ACS_MODE_W-1:0]; // RULE1
         else if (cal_done)
            mode_reg[ACS_MODE_LSB +: 3] <= ACS_OP_IDLE; // RULE4
      end
   end

   // calibration state, period timer and settling countdown
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_state <= ACS_CAL_IDLE;
         cal_op <= ACS_OP_IDLE;
         period_cnt <= '0;
         periods_left <= '0;
      end else if (ce) begin
         if (cal_start) begin
            // restart even if a calibration is already running
            cal_state <= ACS_CAL_RUN;
            cal_op <= acs_op_type'(mode_merged[ACS_MODE_LSB +: 3]); // RULE1
            period_cnt <= '0;
            if (acs_op_type'(mode_merged[ACS_MODE_LSB +: 3]) == ACS_OP_SYS_FULL &&
                mode_merged[ACS_CHOP_BIT])
               periods_left <= ACS_SETTLE_CHOP; // RULE10
            else
               periods_left <= next_periods; // RULE7
         end else begin
            case (cal_state)
               ACS_CAL_IDLE: begin
                  period_cnt <= '0;
               end
               ACS_CAL_RUN: begin
                  if (period_cnt + 20'h1 >= period_len) begin
                     period_cnt <= '0;
                     periods_left <= periods_left - 5'h1;
                     if (periods_left <= 5'h1)
                        cal_state <= ACS_CAL_IDLE;
                  end else begin
                     period_cnt <= period_cnt + 20'h1;
                  end
               end
               default: cal_state <= ACS_CAL_IDLE;
            endcase
         end
      end
   end

   assign cal_done = ce && !cal_start && (cal_state == ACS_CAL_RUN) &&
                     (period_cnt + 20'h1 >= period_len) && (periods_left <= 5'h1);

   // analog input routing during calibration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         input_route <= ACS_ROUTE_PINS;
      end else if (ce) begin
         if (cal_start) begin
            case (acs_op_type'(mode_merged[ACS_MODE_LSB +: 3]))
               ACS_OP_INT_ZERO: input_route <= ACS_ROUTE_ZERO; // RULE5
               ACS_OP_INT_FULL: input_route <= ACS_ROUTE_FULL; // RULE5
               default: input_route <= ACS_ROUTE_PINS; // RULE5
            endcase
         end else if (cal_done) begin
            input_route <= ACS_ROUTE_PINS;
         end
      end
   end

   // latest raw sample taken while calibrating
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_sample <= '0;
      end else if (ce) begin
         if (raw_valid && cal_state == ACS_CAL_RUN)
            cal_sample <= raw_data;
      end
   end

   // coefficient registers: calibration result or host write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offset_coef <= ACS_OFFSET_RESET;
         fullscale_coef <= ACS_FULLSCALE_RESET;
      end else if (ce) begin
         if (cal_done) begin
            if (cal_op == ACS_OP_INT_ZERO || cal_op == ACS_OP_SYS_ZERO)
               offset_coef <= cal_sample; // RULE4
            else
               fullscale_coef <= cal_sample; // RULE4
         end else if (wr_fire && coef_writable) begin
            if (aw_addr == ACS_OFFSET_ADDR)
               offset_coef <= DATA_W'(merge_strb({{(32-DATA_W){1'b0}}, offset_coef}, w_data, w_strb)); // RULE14
            if (aw_addr == ACS_FULLSCALE_ADDR)
               fullscale_coef <= DATA_W'(merge_strb({{(32-DATA_W){1'b0}}, fullscale_coef}, w_data, w_strb)); // RULE14
         end
      end
   end

   // data register takes corrected results outside calibration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_reg <= '0;
      end else if (ce) begin
         if (corr_valid && cal_state == ACS_CAL_IDLE && !cal_start)
            data_reg <= corr_data; // RULE2 RULE16
      end
   end

   // ready bit and shared data-out/ready pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdy_n <= 1'b1;
         dout_rdy <= 1'b1;
      end else if (ce) begin
         if (cal_start) begin
            rdy_n <= 1'b1; // RULE3
            dout_rdy <= 1'b1; // RULE3
         end else if (cal_done) begin
            rdy_n <= 1'b0; // RULE4
            dout_rdy <= cs_n; // RULE4
         end else if (corr_valid && cal_state == ACS_CAL_IDLE) begin
            rdy_n <= 1'b0;
            dout_rdy <= cs_n;
         end else if (cs_n) begin
            dout_rdy <= 1'b1;
         end else begin
            dout_rdy <= rdy_n;
         end
      end
   end

   // sticky interrupt bits, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         if (wr_fire && aw_addr == ACS_IRQ_MASK_ADDR)
            irq_mask <= w_strb[0] ? w_data[ACS_IRQ_W-1:0] : irq_mask;
         irq_stat[ACS_IRQ_CONV_BIT] <= (corr_valid && cal_state == ACS_CAL_IDLE) ||
            (irq_stat[ACS_IRQ_CONV_BIT] &&
             !(wr_fire && aw_addr == ACS_IRQ_STAT_ADDR && w_strb[0] && w_data[ACS_IRQ_CONV_BIT]));
         irq_stat[ACS_IRQ_CAL_BIT] <= cal_done ||
            (irq_stat[ACS_IRQ_CAL_BIT] &&
             !(wr_fire && aw_addr == ACS_IRQ_STAT_ADDR && w_strb[0] && w_data[ACS_IRQ_CAL_BIT]));
         irq <= |(irq_stat & irq_mask);
      end
   end
endmodule // acs_sequencer

// File: tb/acs_checker.sv
// port checker for the calibration sequencer
// assumes ce held high and one aclk domain
module acs_checker
   import acs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cs_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] input_route,
   input wire logic dout_rdy
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // pin and route behaviour
   rdy_deselect_a: assert property (cs_n |=> dout_rdy)
      else $error("ready pin low while deselected");
   cal_not_ready_a: assert property ((input_route != ACS_ROUTE_PINS) [*3] |-> dout_rdy)
      else $error("ready pin low during internal calibration");
   route_legal_a: assert property (input_route != 2'h3)
      else $error("undefined input route");
   route_hold_a: assert property ($changed(input_route) && input_route != ACS_ROUTE_PINS |=> $stable(input_route) [*8])
      else $error("internal route dropped too soon");
   // register bus behaviour
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   err_data_a: assert property (s_axi_rvalid && s_axi_rresp == ACS_RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted before response");
   cover property ($rose(input_route == ACS_ROUTE_ZERO));
   cover property ($rose(input_route == ACS_ROUTE_FULL));
   cover property (s_axi_bvalid && s_axi_bresp == ACS_RESP_SLVERR);
   cover property ($fell(dout_rdy));
endmodule // acs_checker

// File: tb/acs_adc_model.sv
// raw conversion source standing behind the sequencer
// assumes the aclk domain; samples follow the routed input
module acs_adc_model
   import acs_pkg::*;
#(
   parameter int GAP = 7,
   parameter logic [23:0] ZERO_CODE = 24'h000321,
   parameter logic [23:0] FULL_CODE = 24'h7f5a3c
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] input_route,
   input wire logic [23:0] pin_code,
   output logic raw_valid,
   output logic [23:0] raw_data
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   logic [23:0] sample;
   // internal sources replace the pins
   always_comb begin
      case (input_route)
         ACS_ROUTE_ZERO: sample = ZERO_CODE;
         ACS_ROUTE_FULL: sample = FULL_CODE;
         default: sample = pin_code;
      endcase
   end
   // one pulse per gap, data inverted between pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 0;
         raw_valid <= 1'b0;
         raw_data <= 24'h0;
      end else begin
         cnt <= (cnt == GAP) ? 0 : cnt + 1;
         raw_valid <= (cnt == GAP);
         raw_data <= (cnt == GAP) ? sample : ~sample;
      end
   end
endmodule // acs_adc_model

// File: tb/tb.sv
// top bench: bus tasks, calibration table and verdict
// assumes PERIOD_UNIT 4 and rate word 16, one period 64 cycles
module tb
   import acs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [23:0] ZC = 24'h000321;
   localparam logic [23:0] FC = 24'h7f5a3c;
   logic aclk, aresetn, cs_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, raw_valid, dout_rdy, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, input_route, rsp;
   logic [23:0] raw_data, pin_code, cexp;
   logic [2:0] op;
   int n_mismatch = 0;
   int n_compared = 0;
   int lag = 0;
   int n;
   // rate word 16 in every mode word
   logic [31:0] mw [8] = '{32'h04084,
      32'h04086,
      32'h02084,
      32'h02086,
      32'h00085,
      32'h10085,
      32'h18085,
      32'h04087};
   int per [8] = '{3, 3, 2, 2, 4, 8, 16, 3};
   acs_sequencer #(.PERIOD_UNIT(4)) uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cs_n(cs_n), .raw_valid(raw_valid), .raw_data(raw_data),
      .input_route(input_route), .dout_rdy(dout_rdy), .irq(irq));
   acs_adc_model #(.ZERO_CODE(ZC), .FULL_CODE(FC)) model_i (.aclk(aclk), .aresetn(aresetn),
      .input_route(input_route), .pin_code(pin_code), .raw_valid(raw_valid), .raw_data(raw_data));
   // compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one write, each channel released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      repeat (lag) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   // one read
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      repeat (lag) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rd_val = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(nm, e, rd_val);
   endtask
   // start a calibration and see it running
   task automatic cal_go(input logic [31:0] m, input logic [1:0] rt);
      wr(ACS_MODE_ADDR, m);
      repeat (3) @(posedge aclk);
      chk("ready pin", 32'h1, {31'h0, dout_rdy});
      chk("route", {30'h0, rt}, {30'h0, input_route});
   endtask
   // wait for the ready pin, judge length in periods
   task automatic cal_wait(input int p);
      n = 0;
      while (dout_rdy !== 1'b0 && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      chk("periods", 32'(p), 32'((n + 35) / 64));
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // hang guard
   initial begin
      #60000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      aresetn = 1'b0;
      cs_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      pin_code = 24'h123456;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk("mode", ACS_MODE_ADDR, 32'h00312);
      rchk("offset", ACS_OFFSET_ADDR, 32'h800000);
      rchk("fullscale", ACS_FULLSCALE_ADDR, 32'h800000);
      rd(8'h1c);
      chk("unmapped read", {30'h0, ACS_RESP_SLVERR}, {30'h0, rsp});
      wr(ACS_MODE_ADDR, 32'h80);
      wr(ACS_OFFSET_ADDR, 32'h123);
      chk("busy write", {30'h0, ACS_RESP_SLVERR}, {30'h0, rsp});
      rchk("offset", ACS_OFFSET_ADDR, 32'h800000);
      wr(ACS_MODE_ADDR, 32'h82);
      wr(ACS_OFFSET_ADDR, 32'h100);
      chk("idle write", {30'h0, ACS_RESP_OKAY}, {30'h0, rsp});
      wr(ACS_FULLSCALE_ADDR, 32'h400000);
      repeat (20) @(posedge aclk);
      lag = 3;
      rchk("data", ACS_DATA_ADDR, 32'h0919ab);
      lag = 0;
      wr(ACS_OFFSET_ADDR, 32'h0);
      wr(ACS_FULLSCALE_ADDR, 32'h800000);
      wr(ACS_IRQ_MASK_ADDR, 32'h2);
      pin_code <= 24'h200000;
      repeat (20) @(posedge aclk);
      rchk("data", ACS_DATA_ADDR, 32'h200000);
      for (int i = 0; i < 8; i++) begin
         op = mw[i][2:0];
         cal_go(mw[i], op == 3'h4 ? ACS_ROUTE_ZERO : op == 3'h5 ? ACS_ROUTE_FULL : ACS_ROUTE_PINS);
         if (i == 0) begin
            rchk("data", ACS_DATA_ADDR, 32'h200000);
         end
         pin_code <= 24'h300000 + 24'(i * 4369);
         cal_wait(per[i]);
         cexp = (op == 3'h4) ? ZC : (op == 3'h5) ? FC : pin_code;
         rchk("coefficient", op[0] ? ACS_FULLSCALE_ADDR : ACS_OFFSET_ADDR, {8'h0, cexp});
         rchk("mode", ACS_MODE_ADDR, (mw[i] & ~32'h7) | 32'h2);
         rchk("status", ACS_STATUS_ADDR, {27'h0, op, 2'b00});
         if (i == 0) begin
            chk("irq", 32'h1, {31'h0, irq});
            wr(ACS_IRQ_MASK_ADDR, 32'h0);
            repeat (2) @(posedge aclk);
            chk("irq masked", 32'h0, {31'h0, irq});
            rd(ACS_IRQ_STAT_ADDR);
            chk("irq status", 32'h2, rd_val & 32'h2);
            wr(ACS_IRQ_STAT_ADDR, 32'h2);
            rd(ACS_IRQ_STAT_ADDR);
            chk("irq cleared", 32'h0, rd_val & 32'h2);
            wr(ACS_IRQ_MASK_ADDR, 32'h2);
            repeat (2) @(posedge aclk);
            chk("irq idle", 32'h0, {31'h0, irq});
            cs_n <= 1'b1;
            repeat (2) @(posedge aclk);
            chk("pin deselected", 32'h1, {31'h0, dout_rdy});
            cs_n <= 1'b0;
            repeat (2) @(posedge aclk);
            chk("pin selected", 32'h0, {31'h0, dout_rdy});
         end
      end
      give_verdict();
   end
endmodule // tb
bind acs_sequencer acs_checker chk_i (.aclk(aclk), .aresetn(aresetn), .cs_n(cs_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .input_route(input_route), .dout_rdy(dout_rdy));
